// ---- fault_map.vh ----
`ifndef FAULT_MAP_VH
`define FAULT_MAP_VH
// ==========================================
// Register indices (printed offsets, 6-bit address)
`define ADDR_OC_STATUS 6'h06
`define ADDR_IF_STATUS 6'h07
`define ADDR_FAULT_MODE 6'h10
`define ADDR_RETRY_TIME 6'h16
`define ADDR_FAULT_CLEAR 6'h17
// ==========================================
// Reset values
`define RST_FAULT_MODE 16'h0015
`define RST_RETRY_TIME 4'h3
// ==========================================
// Field positions
`define PARITY_BIT 15
`define MODE_WARN_HI 12
`define MODE_WARN_LO 11
`define MODE_OV_HI 10
`define MODE_OV_LO 9
`define MODE_SERIAL_BIT 7
`define MODE_OC_HI 6
`define MODE_OC_LO 4
`define MODE_UV_HI 3
`define MODE_UV_LO 2
`define IF_OTP_BIT 4
`define IF_PARITY_BIT 2
`define IF_CONTENTION_BIT 1
`define IF_FRAMING_BIT 0
`define CLEAR_BIT 0
// ==========================================
// Mode encodings
`define MODE_SLOW 3'h0
`define MODE_FAST 3'h1
`define MODE_LATCH 3'h2
`define MODE_REPORT 3'h3
`define WARN_DISABLED 2'h3
// ==========================================
// Timing: times in microseconds, clock 50 MHz
`define CLK_MHZ 50
`define FAST_T0_US 23'h0001f4
`define FAST_T1_US 23'h0003e8
`define FAST_T2_US 23'h0007d0
`define FAST_T3_US 23'h001388
`define SLOW_T0_US 23'h07a120
`define SLOW_T1_US 23'h0f4240
`define SLOW_T2_US 23'h1e8480
`define SLOW_T3_US 23'h4c4b40
`define TICK_US_CYCLES (`CLK_MHZ)
`endif

// ---- fault_status_mode.v ----
`timescale 1ns/100ps
`default_nettype none
`include "fault_map.vh"
// What this block does
// - High-side overcurrent flags: bit 6 phase C, 5 phase B, 4 phase A.
// - Low-side overcurrent flags: bit 2 phase C, 1 phase B, 0 phase A.
// - Retry overcurrent modes clear the flags themselves on recovery.
// - Clear command or sleep reset pulse clears overcurrent flags.
// - Bit 15 carries parity when parity enable is set, else reserved.
// - Interface bit 4 flags OTP load parity error.
// - Interface bit 2 flags serial frame parity error.
// - Interface bit 1 flags serial bus contention.
// - Interface bit 0 flags malformed serial frame.
// - Warning mode 12-11: slow retry, fast retry, report only, disabled.
// - Overvoltage mode 10-9: slow or fast retry tri-state.
// - Serial fault mode bit 7: report and latch, or disabled.
// - Overcurrent mode 6-4, reset 1: slow, fast, latched, report only.
// - Latched overcurrent keeps pre-driver off until clear command or sleep reset pulse.
// - Undervoltage mode 3-2, reset 1: slow or fast retry tri-state.
// - Any enabled fault asserts fault pin low and latches status.
// - Fast retry code: 0.5, 1, 2, 5 ms.
// - Slow retry code: 0.5, 1, 2, 5 s.
// - Writing clear bit clears latched faults; bit self-resets.
module fault_status_mode
(
   input wire SYS_CLK_I,
   input wire RESET_N_I,
   input wire SLEEP_RESET_I,
   input wire SERIAL_PARITY_ENABLE_I,
   input wire WR_EN_I,
   input wire RD_EN_I,
   input wire [5:0] ADDR_I,
   input wire [15:0] WDATA_I,
   input wire [2:0] HIGH_OVERCURRENT_I,
   input wire [2:0] LOW_OVERCURRENT_I,
   input wire SUPPLY_LOW_WARNING_I,
   input wire OVERVOLTAGE_I,
   input wire UNDERVOLTAGE_I,
   input wire OTP_LOAD_PARITY_ERROR_I,
   input wire SERIAL_PARITY_ERROR_I,
   input wire SERIAL_CONTENTION_ERROR_I,
   input wire SERIAL_FRAMING_ERROR_I,
   output reg [15:0] RDATA_O,
   output reg RVALID_O,
   output reg FAULT_OUT_N_O,
   output reg PREDRIVER_HIZ_O
);
   // ==========================================
   // Retry state machine, one-hot
   localparam ST_RUN = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_LATCH = 3'b100;
   reg [15:0] mode_reg;
   reg [3:0] retry_reg;
   reg [6:0] oc_reg;
   reg [4:0] if_reg;
   reg [2:0] other_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg start_reg;
   reg fast_sel_reg;
   wire tick;
   wire done;
   wire [2:0] oc_mode = mode_reg[`MODE_OC_HI:`MODE_OC_LO];
   wire [1:0] warn_mode = mode_reg[`MODE_WARN_HI:`MODE_WARN_LO];
   wire [1:0] ov_mode = mode_reg[`MODE_OV_HI:`MODE_OV_LO];
   wire [1:0] uv_mode = mode_reg[`MODE_UV_HI:`MODE_UV_LO];
   wire serial_on = ~mode_reg[`MODE_SERIAL_BIT];
   wire clear_cmd = WR_EN_I && (ADDR_I == `ADDR_FAULT_CLEAR) && WDATA_I[`CLEAR_BIT];
   wire clear_all = clear_cmd | SLEEP_RESET_I;
   wire [5:0] oc_now = {HIGH_OVERCURRENT_I, LOW_OVERCURRENT_I};
   wire oc_any = |oc_now;
   wire oc_retry = (oc_mode == `MODE_SLOW) || (oc_mode == `MODE_FAST);
   wire oc_valid = oc_retry || (oc_mode == `MODE_LATCH) || (oc_mode == `MODE_REPORT);
   wire oc_hiz = oc_valid && (oc_mode != `MODE_REPORT);
   wire warn_on = (warn_mode != `WARN_DISABLED);
   wire warn_hiz = warn_on && (warn_mode != `MODE_LATCH);
   // Reserved overvoltage and undervoltage codes fall back to slow retry
   wire ov_fast = (ov_mode == 2'h1);
   wire uv_fast = (uv_mode == 2'h1);
   wire hiz_cause = (oc_any && oc_hiz) || (SUPPLY_LOW_WARNING_I && warn_hiz)
      || OVERVOLTAGE_I || UNDERVOLTAGE_I;
   wire cause_now = hiz_cause;
   // Fast retry if the active cause asks for it
   wire want_fast = (oc_any && oc_hiz && oc_mode == `MODE_FAST)
      || (SUPPLY_LOW_WARNING_I && warn_mode == 2'h1)
      || (OVERVOLTAGE_I && ov_fast) || (UNDERVOLTAGE_I && uv_fast);
   function parity16;
      input [14:0] d;
      begin
         parity16 = ^d;
      end
   endfunction
   // ==========================================
   // Timebase and retry timer
   us_tick u_tick
   (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESET_N_I),
      .tick_o(tick)
   );
   retry_timer u_timer
   (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RESET_N_I),
      .tick_i(tick),
      .start_i(start_reg),
      .fast_i(fast_sel_reg),
      .fast_code_i(retry_reg[1:0]),
      .slow_code_i(retry_reg[3:2]),
      .done_o(done)
   );
   // ==========================================
   // Configuration registers
   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         mode_reg <= `RST_FAULT_MODE;
         retry_reg <= `RST_RETRY_TIME;
      end
      else if (WR_EN_I)
      begin
         if (ADDR_I == `ADDR_FAULT_MODE)
         begin
            // Reserved bits 14-13 and 8 kept zero
            mode_reg <= {WDATA_I[15], 2'h0, WDATA_I[12:9], 1'b0, WDATA_I[7:0]};
         end
         if (ADDR_I == `ADDR_RETRY_TIME)
         begin
            retry_reg <= WDATA_I[3:0];
         end
      end
   end
   // ==========================================
   // Status flags; a new event wins over a clear
   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         oc_reg <= 7'h00;
         if_reg <= 5'h00;
         other_reg <= 3'h0;
      end
      else
      begin
         if (oc_valid && oc_any)
         begin
            oc_reg <= (clear_all ? 7'h00 : oc_reg) | {oc_now[5:3], 1'b0, oc_now[2:0]};
         end
         else if (clear_all || (oc_retry && state_reg == ST_RUN && !oc_any && !start_reg))
         begin
            oc_reg <= 7'h00;
         end
         // Serial flags stay until a clear; no self-recovery in this mode
         if (clear_all)
         begin
            if_reg <= 5'h00;
         end
         if (OTP_LOAD_PARITY_ERROR_I)
         begin
            if_reg[`IF_OTP_BIT] <= 1'b1;
         end
         if (serial_on)
         begin
            if (SERIAL_PARITY_ERROR_I)
            begin
               if_reg[`IF_PARITY_BIT] <= 1'b1;
            end
            if (SERIAL_CONTENTION_ERROR_I)
            begin
               if_reg[`IF_CONTENTION_BIT] <= 1'b1;
            end
            if (SERIAL_FRAMING_ERROR_I)
            begin
               if_reg[`IF_FRAMING_BIT] <= 1'b1;
            end
         end
         other_reg <= (clear_all ? 3'h0 : other_reg)
            | {SUPPLY_LOW_WARNING_I && warn_on, OVERVOLTAGE_I, UNDERVOLTAGE_I};
      end
   end
   // ==========================================
   // Pre-driver retry control
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
         begin
            if (oc_any && oc_mode == `MODE_LATCH)
            begin
               state_next = ST_LATCH;
            end
            else if (cause_now)
            begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (oc_any && oc_mode == `MODE_LATCH)
            begin
               state_next = ST_LATCH;
            end
            else if (done && !start_reg && !cause_now)
            begin
               state_next = ST_RUN;
            end
         end
         ST_LATCH:
         begin
            if (clear_all)
            begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_RUN;
      endcase
   end
   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         state_reg <= ST_RUN;
         start_reg <= 1'b0;
         fast_sel_reg <= 1'b0;
         PREDRIVER_HIZ_O <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         // Restart delay while the fault persists so timing counts from its end
         start_reg <= (state_next == ST_WAIT) && cause_now;
         if (cause_now)
         begin
            fast_sel_reg <= want_fast;
         end
         PREDRIVER_HIZ_O <= (state_next != ST_RUN);
      end
   end
   // ==========================================
   // Fault pin and register reads
   always @(posedge SYS_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         FAULT_OUT_N_O <= 1'b1;
         RDATA_O <= 16'h0000;
         RVALID_O <= 1'b0;
      end
      else
      begin
         FAULT_OUT_N_O <= ~((|oc_reg) || (|if_reg) || (|other_reg));
         RVALID_O <= RD_EN_I;
         if (RD_EN_I)
         begin
            case (ADDR_I)
               `ADDR_OC_STATUS: RDATA_O <= pwrap({8'h00, 1'b0, oc_reg});
               `ADDR_IF_STATUS: RDATA_O <= pwrap({11'h000, if_reg});
               `ADDR_FAULT_MODE: RDATA_O <= pwrap(mode_reg);
               `ADDR_RETRY_TIME: RDATA_O <= pwrap({12'h000, retry_reg});
               default: RDATA_O <= 16'h0000;
            endcase
         end
      end
   end
   function [15:0] pwrap;
      input [15:0] d;
      begin
         pwrap = {SERIAL_PARITY_ENABLE_I & parity16(d[14:0]), d[14:0]};
      end
   endfunction
endmodule
`default_nettype wire

// ---- fault_status_mode_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Register bus, fault pin and pre-driver checks
module fault_status_mode_sva
(
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   input wire logic SLEEP_RESET_I,
   input wire logic SERIAL_PARITY_ENABLE_I,
   input wire logic WR_EN_I,
   input wire logic RD_EN_I,
   input wire logic [5:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic [2:0] HIGH_OVERCURRENT_I,
   input wire logic [2:0] LOW_OVERCURRENT_I,
   input wire logic SUPPLY_LOW_WARNING_I,
   input wire logic OVERVOLTAGE_I,
   input wire logic UNDERVOLTAGE_I,
   input wire logic OTP_LOAD_PARITY_ERROR_I,
   input wire logic SERIAL_PARITY_ERROR_I,
   input wire logic SERIAL_CONTENTION_ERROR_I,
   input wire logic SERIAL_FRAMING_ERROR_I,
   input wire logic [15:0] RDATA_O,
   input wire logic RVALID_O,
   input wire logic FAULT_OUT_N_O,
   input wire logic PREDRIVER_HIZ_O
);
   // Drive-side faults only; serial errors never tri-state
   wire drv_fault = |HIGH_OVERCURRENT_I || |LOW_OVERCURRENT_I || SUPPLY_LOW_WARNING_I
      || OVERVOLTAGE_I || UNDERVOLTAGE_I;
   wire quiet = !drv_fault && !OTP_LOAD_PARITY_ERROR_I && !SERIAL_PARITY_ERROR_I
      && !SERIAL_CONTENTION_ERROR_I && !SERIAL_FRAMING_ERROR_I;
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   AST_READ_ANSWER: assert property (RD_EN_I |=> RVALID_O)
      else $error("read not answered next cycle");
   AST_NO_STRAY_VALID: assert property (!RD_EN_I |=> !RVALID_O)
      else $error("valid without read");
   AST_UNMAPPED_ZERO: assert property (RD_EN_I && ADDR_I == 6'h3f |=> RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   AST_PARITY_OFF: assert property (RD_EN_I && !SERIAL_PARITY_ENABLE_I |=> !RDATA_O[15])
      else $error("top bit set with parity off");
   AST_PARITY_ON: assert property (RD_EN_I && SERIAL_PARITY_ENABLE_I
      |=> RDATA_O[15] == ^RDATA_O[14:0])
      else $error("parity bit wrong");
   AST_DATA_HOLDS: assert property (!RD_EN_I |=> $stable(RDATA_O))
      else $error("read data changed without read");
   AST_SLEEP_CLEARS: assert property (SLEEP_RESET_I && quiet ##1 quiet |=> FAULT_OUT_N_O)
      else $error("fault pin low after sleep reset");
   AST_CLEAR_CMD: assert property (WR_EN_I && ADDR_I == 6'h17 && WDATA_I[0] && quiet
      ##1 quiet |=> FAULT_OUT_N_O)
      else $error("fault pin low after clear");
   AST_HIZ_CAUSE: assert property ($rose(PREDRIVER_HIZ_O) |-> $past(drv_fault))
      else $error("pre-driver off without fault");
   cover property (RVALID_O && RDATA_O[15]);
   cover property ($fell(PREDRIVER_HIZ_O));
   cover property ($fell(FAULT_OUT_N_O));
endmodule
bind fault_status_mode fault_status_mode_sva i_fault_status_mode_sva (.*);
`default_nettype wire

// ---- fault_status_mode_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "fault_map.vh"
// ==========================================
// Fault status and mode bench
module fault_status_mode_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sleep_rst = 1'b0;
   logic pen = 1'b0;
   logic [2:0] hi = 3'h0;
   logic [2:0] lo = 3'h0;
   logic [3:0] ifc = 4'h0;
   logic [2:0] sup = 3'h0;
   logic wr, rd, rvalid, fault_n, hiz;
   logic [5:0] addr;
   logic [15:0] wdata, rdata, d;
   logic [47:0] rows [11];
   int errors = 0;
   int total_checks = 0;
   int i, n;
   always #10 clk = ~clk;
   fault_status_mode i_fault_status_mode (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
      .SLEEP_RESET_I(sleep_rst), .SERIAL_PARITY_ENABLE_I(pen), .WR_EN_I(wr), .RD_EN_I(rd),
      .ADDR_I(addr), .WDATA_I(wdata), .HIGH_OVERCURRENT_I(hi), .LOW_OVERCURRENT_I(lo),
      .SUPPLY_LOW_WARNING_I(sup[2]), .OVERVOLTAGE_I(sup[1]), .UNDERVOLTAGE_I(sup[0]),
      .OTP_LOAD_PARITY_ERROR_I(ifc[3]), .SERIAL_PARITY_ERROR_I(ifc[2]),
      .SERIAL_CONTENTION_ERROR_I(ifc[1]), .SERIAL_FRAMING_ERROR_I(ifc[0]),
      .RDATA_O(rdata), .RVALID_O(rvalid), .FAULT_OUT_N_O(fault_n), .PREDRIVER_HIZ_O(hiz));
   serial_host_model i_serial_host_model (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata),
      .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk16({15'h0, g}, {15'h0, e});
   endtask
   task automatic pulse(input logic [9:0] f);
      @(negedge clk);
      {hi, lo, ifc} = f;
      @(negedge clk);
      {hi, lo, ifc} = 10'h0;
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #800000;
      errors++;
      finish_test;
   end
   initial
   begin
      // Row: mode, faults {hi, lo, otp, parity, contention, framing}, address, status
      rows = '{{16'h0020, 10'h080, 6'h06, 16'h0010}, {16'h0020, 10'h100, 6'h06, 16'h0020},
         {16'h0020, 10'h200, 6'h06, 16'h0040}, {16'h0020, 10'h070, 6'h06, 16'h0007},
         {16'h0030, 10'h080, 6'h06, 16'h0010}, {16'h0040, 10'h040, 6'h06, 16'h0000},
         {16'h0015, 10'h008, 6'h07, 16'h0010}, {16'h0015, 10'h004, 6'h07, 16'h0004},
         {16'h0015, 10'h002, 6'h07, 16'h0002}, {16'h0015, 10'h001, 6'h07, 16'h0001},
         {16'h0095, 10'h001, 6'h07, 16'h0000}};
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      i_serial_host_model.rd(`ADDR_FAULT_MODE, d);
      chk16(d, 16'h0015);
      i_serial_host_model.rd(`ADDR_IF_STATUS, d);
      chk16(d, 16'h0000);
      $display("test reset done");
      for (i = 0; i < 11; i++)
      begin
         i_serial_host_model.wr(`ADDR_FAULT_MODE, rows[i][47:32]);
         pulse(rows[i][31:22]);
         i_serial_host_model.rd(rows[i][21:16], d);
         chk16(d, rows[i][15:0]);
         chk1(fault_n, rows[i][15:0] == 16'h0);
         chk1(hiz, rows[i][38:36] == 3'h2 && rows[i][31:26] != 6'h0);
         i_serial_host_model.clr();
         i_serial_host_model.rd(rows[i][21:16], d);
         chk16(d, 16'h0000);
         chk1(fault_n, 1'b1);
         chk1(hiz, 1'b0);
         $display("test row %0d done", i);
      end
      // Parity, unmapped read, write to read-only status
      i_serial_host_model.wr(`ADDR_FAULT_MODE, 16'h0015);
      pen = 1'b1;
      i_serial_host_model.rd(`ADDR_FAULT_MODE, d);
      chk16(d, 16'h8015);
      pen = 1'b0;
      i_serial_host_model.rd(6'h3f, d);
      chk16(d, 16'h0000);
      i_serial_host_model.wr(`ADDR_IF_STATUS, 16'hffff);
      i_serial_host_model.rd(`ADDR_IF_STATUS, d);
      chk16(d, 16'h0000);
      $display("test parity done");
      // Sleep pulse clears a latched flag
      i_serial_host_model.wr(`ADDR_FAULT_MODE, 16'h0020);
      pulse(10'h080);
      @(negedge clk);
      sleep_rst = 1'b1;
      @(negedge clk);
      sleep_rst = 1'b0;
      i_serial_host_model.rd(`ADDR_OC_STATUS, d);
      chk16(d, 16'h0000);
      chk1(fault_n, 1'b1);
      $display("test sleep done");
      // Warning report only, then disabled
      i_serial_host_model.wr(`ADDR_FAULT_MODE, 16'h1015);
      @(negedge clk);
      sup = 3'h4;
      @(negedge clk);
      sup = 3'h0;
      @(negedge clk);
      chk1(fault_n, 1'b0);
      chk1(hiz, 1'b0);
      i_serial_host_model.clr();
      i_serial_host_model.wr(`ADDR_FAULT_MODE, 16'h1815);
      @(negedge clk);
      sup = 3'h4;
      @(negedge clk);
      sup = 3'h0;
      @(negedge clk);
      chk1(fault_n, 1'b1);
      $display("test warning done");
      // Fast retry code 0: 500 us at 50 cycles per us
      i_serial_host_model.wr(`ADDR_RETRY_TIME, 16'h0000);
      i_serial_host_model.wr(`ADDR_FAULT_MODE, 16'h0015);
      pulse(10'h040);
      chk1(hiz, 1'b1);
      for (n = 0; n < 30000 && hiz === 1'b1; n++)
         @(negedge clk);
      chk1(n > 24900 && n < 25100, 1'b1);
      i_serial_host_model.rd(`ADDR_OC_STATUS, d);
      chk16(d, 16'h0000);
      chk1(fault_n, 1'b1);
      $display("test retry done");
      finish_test;
   end
endmodule
`default_nettype wire

// ---- retry_timer.v ----
`timescale 1ns/100ps
`default_nettype none
`include "fault_map.vh"
// ==========================================
// Retry delay timer, counts microsecond ticks
module retry_timer
(
   input wire clk_i,
   input wire rst_n_i,
   input wire tick_i,
   input wire start_i,
   input wire fast_i,
   input wire [1:0] fast_code_i,
   input wire [1:0] slow_code_i,
   output reg done_o
);
   reg [22:0] cnt_reg;
   reg [22:0] limit;
   reg run_reg;
   function [22:0] delay_us;
      input fast;
      input [1:0] code;
      begin
         case ({fast, code})
            3'h4: delay_us = `FAST_T0_US;
            3'h5: delay_us = `FAST_T1_US;
            3'h6: delay_us = `FAST_T2_US;
            3'h7: delay_us = `FAST_T3_US;
            3'h0: delay_us = `SLOW_T0_US;
            3'h1: delay_us = `SLOW_T1_US;
            3'h2: delay_us = `SLOW_T2_US;
            default: delay_us = `SLOW_T3_US;
         endcase
      end
   endfunction
   always @*
   begin
      limit = delay_us(fast_i, fast_i ? fast_code_i : slow_code_i);
   end
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_reg <= 23'h000000;
         run_reg <= 1'b0;
         done_o <= 1'b0;
      end
      else if (start_i)
      begin
         cnt_reg <= 23'h000000;
         run_reg <= 1'b1;
         done_o <= 1'b0;
      end
      else if (run_reg && tick_i)
      begin
         if (cnt_reg >= limit - 23'h000001)
         begin
            run_reg <= 1'b0;
            done_o <= 1'b1;
         end
         cnt_reg <= cnt_reg + 23'h000001;
      end
   end
endmodule
`default_nettype wire

// ---- serial_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Controller side of the register bus
module serial_host_model
(
   input wire logic clk_i,
   input wire logic rvalid_i,
   input wire logic [15:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [5:0] addr_o,
   output logic [15:0] wdata_o
);
   initial
   begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 6'h2a;
      wdata_o = 16'h5a5a;
   end
   // Idle bus shows inverted values, so stale data never looks valid
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk_i);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      int n;
      @(negedge clk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      for (n = 0; n < 4 && rvalid_i !== 1'b1; n++)
         @(negedge clk_i);
      d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
   endtask
   // Latched faults stay until the controller clears them
   task automatic clr();
      wr(6'h17, 16'h0001);
   endtask
endmodule
`default_nettype wire

// ---- us_tick.v ----
`timescale 1ns/100ps
`default_nettype none
`include "fault_map.vh"
// ==========================================
// One-microsecond enable pulse divider
module us_tick
(
   input wire clk_i,
   input wire rst_n_i,
   output reg tick_o
);
   reg [5:0] cnt_reg;
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_reg <= 6'h00;
         tick_o <= 1'b0;
      end
      else if (cnt_reg == (`TICK_US_CYCLES - 1))
      begin
         cnt_reg <= 6'h00;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 6'h01;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire
